// ===== dcsw_core.v
`timescale 1ns/1ps
`include "dcsw_map.vh"

// Behaviour
// - Bit5 low holds ramp output, high tracks
// - Bit6 low ramps down, high ramps up
// - Bit7 rise acknowledges faults, may inhibit
// - Bit10 low ignores fieldbus process data
// - Bit11 inverts setpoint sign
// - Bit13 increments motorized pot setpoint
// - Bit14 decrements motorized pot setpoint
// - State bit0 ready to start
// - State bit1 ready: on, no fault
// - State bit2 operation enabled
// - State bit3 fault present
// - State bits4,5 coast/quick stop inactive
// - State bit6 switch-on inhibit active
// - State bit7 alarm, no acknowledge
// - State bit8 speed within tolerance
// - State bit9 master control request
// - State bit10 speed at comparison level
// - State bit11 torque below limit
// - State bit13 low on motor overtemperature
// - State bit14 shows rotation direction
// - State bit15 low on drive overload
// - Bit0 rise switches on, low ramps off
// - Bit3 low cancels pulses at once
// - Bit1 low coasts motor immediately
// - Bit2 low quick stop ramps down
module dcsw_core #(
    parameter SW = 16,            // Setpoint and speed width
    parameter POT_STEP = 16'h0001 // Pot change per enabled cycle
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    // Command word from the fieldbus receiver
    input wire [15:0] drive_command_word_i,
    input wire cmd_valid_i,
    // Drive conditions, all but standstill from outside the clock domain
    input wire supply_ok_i,
    input wire init_done_i,
    input wire fault_i,
    input wire alarm_i,
    input wire master_req_i,
    input wire mot_overtemp_i,
    input wire drv_overload_i,
    input wire standstill_i,
    // Speed and torque values, same domain
    input wire signed [SW-1:0] setpoint_i,
    input wire signed [SW-1:0] actual_speed_i,
    input wire [SW-1:0] speed_tol_i,
    input wire signed [SW-1:0] cmp_speed_i,
    input wire [SW-1:0] torque_i,
    input wire [SW-1:0] torque_limit_i,
    // Drive control outputs
    output reg pulse_enable_o,
    output reg ramp_hold_o,
    output reg ramp_down_o,
    output reg quick_stop_o,
    output reg coast_o,
    output reg fault_ack_o,
    output reg signed [SW-1:0] setpoint_o,
    output reg signed [SW-1:0] pot_value_o,
    output reg [15:0] drive_state_word_o
);
    ////////////////////////////////////////////////////////////////////////
    // Drive state machine, one-hot
    // Inhibit: pulses locked, a fresh on edge is needed before start
    // Ready to start: supply and init fine, waiting for the on edge
    // Ready: on seen, waiting for enable operation
    // Run: pulses may be enabled, motor follows the setpoint
    // One-hot keeps state word bits 0, 2 and 6 a single flop read each
    localparam ST_INHIBIT = 4'b0001; // Switch-on inhibited
    localparam ST_READY_START = 4'b0010;
    localparam ST_READY = 4'b0100;
    localparam ST_RUN = 4'b1000;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [15:0] cmd_reg;      // Latched command word
    reg on_prev_reg;         // Previous on bit, edge detect
    reg ack_prev_reg;        // Previous acknowledge bit
    reg fault_latch_reg;     // Sticky fault until acknowledged
    reg signed [SW-1:0] pot_reg;
    wire [6:0] async_raw;
    wire [6:0] async_s;      // Synchronised drive conditions
    wire on_b;
    wire no_coast_b;
    wire no_quick_b;
    wire en_op_b;
    wire ack_rise;
    wire on_rise;
    wire fault_now;
    wire signed [SW:0] spd_diff;
    wire [SW:0] spd_abs;
    wire bus_ok;
    wire power_ok;           // Supply and init both seen

    // Synchronised condition bits, index by index:
    // 0 supply present
    // 1 initialisation finished
    // 2 fault
    // 3 alarm
    // 4 master control request
    // 5 motor overtemperature
    // 6 drive thermal overload
    // All seven share one chain, so they arrive together
    assign async_raw = {drv_overload_i, mot_overtemp_i, master_req_i,
                        alarm_i, fault_i, init_done_i, supply_ok_i};

    // Both needed before anything leaves inhibit
    assign power_ok = async_s[0] & async_s[1];

    // Drive conditions come from other boards; four flops each
    // trade four cycles of latency for a clean, filtered level
    dcsw_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .d_i(async_raw),
        .q_o(async_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command capture; bus control bit itself always accepted
    // A word without the takeover bit changes nothing but that bit,
    // so the master can hand control back without side effects.
    // Hazard: the word is taken on the valid strobe only, so a
    // glitching idle word between frames is never seen.
    // Reserved bits are masked at capture so no later logic can
    // react to them.
    assign bus_ok = drive_command_word_i[`DCSW_CMD_BUS_CTRL];

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_reg <= `DCSW_CMD_RESET;
        end else if (ce_i && cmd_valid_i) begin
            if (bus_ok) begin
                // Reserved bits 8, 9, 12 and 15 are dropped
                cmd_reg <= drive_command_word_i & 16'h6cff;
            end else begin
                // Not in charge: keep old control, just clear takeover
                cmd_reg <= cmd_reg & ~16'h0400;
            end
        end
    end

    // Decoded fields of the stored word
    assign on_b = cmd_reg[`DCSW_CMD_ON];
    assign no_coast_b = cmd_reg[`DCSW_CMD_NO_COAST];
    assign no_quick_b = cmd_reg[`DCSW_CMD_NO_QUICK];
    assign en_op_b = cmd_reg[`DCSW_CMD_ENABLE_OP];
    assign on_rise = on_b & ~on_prev_reg;
    assign ack_rise = cmd_reg[`DCSW_CMD_FAULT_ACK] & ~ack_prev_reg;
    assign fault_now = fault_latch_reg | async_s[2];

    ////////////////////////////////////////////////////////////////////////
    // Edge history and fault latch; new fault beats acknowledge
    // The previous bits move only with ce_i, so an edge held across
    // a frozen stretch is still seen exactly once.
    // A fault present during the acknowledge stays latched.
    // Both edge detectors start at zero to match the reset word.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            on_prev_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
            fault_latch_reg <= 1'b0;
        end else if (ce_i) begin
            on_prev_reg <= on_b;
            ack_prev_reg <= cmd_reg[`DCSW_CMD_FAULT_ACK];
            // Set wins over a same-cycle acknowledge
            if (async_s[2]) begin
                fault_latch_reg <= 1'b1;
            end else if (ack_rise) begin
                fault_latch_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    // Coast stop and faults drop straight to inhibit; ramp and quick
    // stops leave run only once the motor reports standstill.
    // Inhibit is left only with on dropped, so an on level that was
    // already high can never start the motor by itself.
    // Acknowledge with on held overrides every branch below.
    // Supply or init loss is handled in the state register, not here,
    // so every branch here assumes the electronics are up.
    // Standstill comes from the drive, in this clock domain.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_INHIBIT: begin
                // Leave only once on is dropped and no fault remains
                if (!on_b && !fault_now && no_coast_b && no_quick_b) begin
                    state_next = ST_READY_START;
                end
            end
            ST_READY_START: begin
                if (fault_now || !no_coast_b || !no_quick_b) begin
                    state_next = ST_INHIBIT;
                end else if (on_rise) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (fault_now || !no_coast_b) begin
                    state_next = ST_INHIBIT;
                end else if (!on_b || !no_quick_b) begin
                    state_next = ST_READY_START;
                end else if (en_op_b) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_now || !no_coast_b) begin
                    state_next = ST_INHIBIT;
                end else if (!en_op_b) begin
                    state_next = ST_READY;
                end else if ((!on_b || !no_quick_b) && standstill_i) begin
                    // Ramp or quick stop finished at standstill
                    state_next = ST_READY_START;
                end
            end
            default: begin
                // Illegal code recovers to the safe state
                state_next = ST_INHIBIT;
            end
        endcase
        // Acknowledge with on still held lands in inhibit
        if (ack_rise && on_b) begin
            state_next = ST_INHIBIT;
        end
    end

    // State register; power loss overrides the next-state logic
    // and holds the machine in inhibit until both conditions return
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_INHIBIT;
        end else if (ce_i) begin
            // Without supply and initialisation, stay inhibited
            if (!power_ok) begin
                state_reg <= ST_INHIBIT;
            end else begin
                state_reg <= state_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive control outputs
    // All registered, one cycle behind the stored command.
    // Pulses also need supply and init, since the next-state value
    // alone does not see the power override of the state register.
    // Ramp down covers both setpoint inhibit and a dropped on bit.
    // Quick stop and coast follow their bits directly; the state
    // machine decides what they do to the motor.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_enable_o <= 1'b0;
            ramp_hold_o <= 1'b1;
            ramp_down_o <= 1'b1;
            quick_stop_o <= 1'b0;
            coast_o <= 1'b1;
            fault_ack_o <= 1'b0;
        end else if (ce_i) begin
            // Pulses only in run with operation enabled
            pulse_enable_o <= power_ok & state_next[3] & en_op_b;
            ramp_hold_o <= ~cmd_reg[`DCSW_CMD_RAMP_RUN];
            ramp_down_o <= ~cmd_reg[`DCSW_CMD_SETP_EN] | ~on_b;
            quick_stop_o <= ~no_quick_b;
            coast_o <= ~no_coast_b;
            fault_ack_o <= ack_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Motorized pot and setpoint direction
    // The pot wraps at full scale; no clamp is applied here, so
    // the master must stop stepping before the range ends.
    // Reversal negates the incoming setpoint; the most negative
    // value negates onto itself, a known limit of two's complement.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pot_reg <= `DCSW_POT_RESET;
            pot_value_o <= `DCSW_POT_RESET;
            setpoint_o <= `DCSW_POT_RESET;
        end else if (ce_i) begin
            // Both up and down together cancel out
            if (cmd_reg[`DCSW_CMD_POT_UP] && !cmd_reg[`DCSW_CMD_POT_DOWN]) begin
                pot_reg <= pot_reg + POT_STEP[SW-1:0];
            end else if (cmd_reg[`DCSW_CMD_POT_DOWN] && !cmd_reg[`DCSW_CMD_POT_UP]) begin
                pot_reg <= pot_reg - POT_STEP[SW-1:0];
            end
            // Output lags the pot by one cycle
            pot_value_o <= pot_reg;
            if (cmd_reg[`DCSW_CMD_REVERSE]) begin
                setpoint_o <= -setpoint_i;
            end else begin
                setpoint_o <= setpoint_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State word assembly
    // Speed deviation is worked one bit wider so the magnitude
    // of any difference of two full-range values still fits.
    assign spd_diff = {setpoint_i[SW-1], setpoint_i} - {actual_speed_i[SW-1], actual_speed_i};
    assign spd_abs = spd_diff[SW] ? -spd_diff : spd_diff;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_state_word_o <= 16'h0000;
        end else if (ce_i) begin
            // Motor state bits, one flop each
            drive_state_word_o[`DCSW_ST_READY_START] <= state_reg[1];
            drive_state_word_o[`DCSW_ST_READY] <= (state_reg[2] | state_reg[3])
                                                  & ~fault_now;
            drive_state_word_o[`DCSW_ST_OP_EN] <= state_reg[3];
            // Fault shows the latch, so a cleared input still reads set
            drive_state_word_o[`DCSW_ST_FAULT] <= fault_now;
            drive_state_word_o[`DCSW_ST_NO_COAST] <= no_coast_b;
            drive_state_word_o[`DCSW_ST_NO_QUICK] <= no_quick_b;
            drive_state_word_o[`DCSW_ST_INHIBIT] <= state_reg[0];
            drive_state_word_o[`DCSW_ST_ALARM] <= async_s[3];
            // Speed and torque compares, same-domain inputs
            drive_state_word_o[`DCSW_ST_SPD_TOL] <= spd_abs <= {1'b0, speed_tol_i};
            drive_state_word_o[`DCSW_ST_MASTER_REQ] <= async_s[4];
            drive_state_word_o[`DCSW_ST_SPD_CMP] <= actual_speed_i >= cmp_speed_i;
            drive_state_word_o[`DCSW_ST_TRQ_OK] <= torque_i < torque_limit_i;
            // Reserved bit reads as zero
            drive_state_word_o[12] <= 1'b0;
            // Thermal alarms read low while active
            drive_state_word_o[`DCSW_ST_MOT_TEMP_N] <= ~async_s[5];
            // Zero speed keeps the last direction shown
            if (actual_speed_i != {SW{1'b0}}) begin
                drive_state_word_o[`DCSW_ST_DIR_CW] <= ~actual_speed_i[SW-1];
            end
            drive_state_word_o[`DCSW_ST_DRV_TEMP_N] <= ~async_s[6];
        end
    end
endmodule

// ===== dcsw_map.vh
`ifndef DCSW_MAP_VH
`define DCSW_MAP_VH
// Command word bit positions
`define DCSW_CMD_ON 0
`define DCSW_CMD_NO_COAST 1
`define DCSW_CMD_NO_QUICK 2
`define DCSW_CMD_ENABLE_OP 3
`define DCSW_CMD_RAMP_EN 4
`define DCSW_CMD_RAMP_RUN 5
`define DCSW_CMD_SETP_EN 6
`define DCSW_CMD_FAULT_ACK 7
`define DCSW_CMD_BUS_CTRL 10
`define DCSW_CMD_REVERSE 11
`define DCSW_CMD_POT_UP 13
`define DCSW_CMD_POT_DOWN 14
// State word bit positions
`define DCSW_ST_READY_START 0
`define DCSW_ST_READY 1
`define DCSW_ST_OP_EN 2
`define DCSW_ST_FAULT 3
`define DCSW_ST_NO_COAST 4
`define DCSW_ST_NO_QUICK 5
`define DCSW_ST_INHIBIT 6
`define DCSW_ST_ALARM 7
`define DCSW_ST_SPD_TOL 8
`define DCSW_ST_MASTER_REQ 9
`define DCSW_ST_SPD_CMP 10
`define DCSW_ST_TRQ_OK 11
`define DCSW_ST_MOT_TEMP_N 13
`define DCSW_ST_DIR_CW 14
`define DCSW_ST_DRV_TEMP_N 15
// Reset values
`define DCSW_CMD_RESET 16'h0000
`define DCSW_POT_RESET 16'h0000
`endif

// ===== dcsw_sync.v
`timescale 1ns/1ps
// Three-stage input synchroniser; output changes once stages two and three agree
module dcsw_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] s1_reg; // Metastability catcher, read only by s2
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    integer k;

    ////////////////////////////////////////////////////////////////////////
    // Shift chain and per-bit agreement filter
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
            s3_reg <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (k = 0; k < WIDTH; k = k + 1) begin
                // Only accept a bit once two stages agree
                if (s2_reg[k] == s3_reg[k]) begin
                    q_o[k] <= s3_reg[k];
                end
            end
        end
    end
endmodule

// ===== dcsw_master_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Fieldbus master: one command word per edge while sending
module dcsw_master_model (
    input wire clk_i,
    input wire [15:0] word_i,
    input wire send_i,
    output logic [15:0] drive_command_word_o = 16'h0000,
    output logic cmd_valid_o = 1'b0
);
    // Idle word toggles so a stale value is never mistaken for data
    always @(posedge clk_i) begin
        cmd_valid_o <= send_i;
        if (send_i) begin
            drive_command_word_o <= word_i & 16'h6cff;
        end else begin
            drive_command_word_o <= ~drive_command_word_o;
        end
    end
endmodule

// ===== dcsw_core_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Port checker for the command and state word core
module dcsw_core_monitor #(
    parameter SW = 16,
    parameter POT_STEP = 16'h0001
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [15:0] drive_command_word_i,
    input wire cmd_valid_i,
    input wire signed [SW-1:0] setpoint_i,
    input wire signed [SW-1:0] actual_speed_i,
    input wire signed [SW-1:0] cmp_speed_i,
    input wire [SW-1:0] torque_i,
    input wire [SW-1:0] torque_limit_i,
    input wire pulse_enable_o,
    input wire ramp_hold_o,
    input wire ramp_down_o,
    input wire quick_stop_o,
    input wire coast_o,
    input wire fault_ack_o,
    input wire signed [SW-1:0] setpoint_o,
    input wire signed [SW-1:0] pot_value_o,
    input wire [15:0] drive_state_word_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Same accepted word for four edges, so the pipeline has settled
    sequence held_s;
        (ce_i && cmd_valid_i && drive_command_word_i[10] && $stable(drive_command_word_i)
            && $stable(setpoint_i))[*4];
    endsequence
    // Speed inputs steady long enough for the compare stage
    sequence spd_s;
        (ce_i && $stable(actual_speed_i) && $stable(cmp_speed_i) && $stable(torque_i)
            && $stable(torque_limit_i))[*3];
    endsequence
    ////////////////////////////////////////////////////////////
    coast_follow_a: assert property (held_s |-> coast_o == !drive_command_word_i[1])
        else $error("coast output disagrees with command");
    quick_follow_a: assert property (held_s |-> quick_stop_o == !drive_command_word_i[2])
        else $error("quick stop output disagrees with command");
    ramp_hold_a: assert property (held_s |-> ramp_hold_o == !drive_command_word_i[5])
        else $error("ramp hold disagrees with command");
    ramp_down_a: assert property (held_s ##0 !drive_command_word_i[6] |-> ramp_down_o)
        else $error("no ramp down with setpoint inhibited");
    pulse_cut_a: assert property (held_s ##0 !drive_command_word_i[3] |-> !pulse_enable_o)
        else $error("pulses enabled while operation inhibited");
    reverse_sign_a: assert property (held_s |-> setpoint_o ==
        (drive_command_word_i[11] ? -setpoint_i : setpoint_i))
        else $error("setpoint sign wrong");
    pot_up_a: assert property (held_s ##0 (drive_command_word_i[14:13] == 2'b01)
        |=> pot_value_o == $past(pot_value_o) + POT_STEP)
        else $error("pot did not step up");
    pot_down_a: assert property (held_s ##0 (drive_command_word_i[14:13] == 2'b10)
        |=> pot_value_o == $past(pot_value_o) - POT_STEP)
        else $error("pot did not step down");
    ack_single_a: assert property (fault_ack_o && ce_i |=> !fault_ack_o)
        else $error("fault acknowledge longer than one cycle");
    spd_reach_a: assert property (spd_s |->
        drive_state_word_o[10] == (actual_speed_i >= cmp_speed_i))
        else $error("comparison speed bit wrong");
    trq_below_a: assert property (spd_s |->
        drive_state_word_o[11] == (torque_i < torque_limit_i))
        else $error("torque bit wrong");
    resv_zero_a: assert property (!drive_state_word_o[12])
        else $error("reserved state bit set");
    // Main scenarios
    cover property (fault_ack_o);
    cover property (pulse_enable_o);
    cover property (held_s ##0 drive_command_word_i[11]);
endmodule

bind dcsw_core dcsw_core_monitor #(.SW(SW), .POT_STEP(POT_STEP)) u_mon (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .drive_command_word_i(drive_command_word_i),
    .cmd_valid_i(cmd_valid_i),
    .setpoint_i(setpoint_i),
    .actual_speed_i(actual_speed_i),
    .cmp_speed_i(cmp_speed_i),
    .torque_i(torque_i),
    .torque_limit_i(torque_limit_i),
    .pulse_enable_o(pulse_enable_o),
    .ramp_hold_o(ramp_hold_o),
    .ramp_down_o(ramp_down_o),
    .quick_stop_o(quick_stop_o),
    .coast_o(coast_o),
    .fault_ack_o(fault_ack_o),
    .setpoint_o(setpoint_o),
    .pot_value_o(pot_value_o),
    .drive_state_word_o(drive_state_word_o)
);

// ===== tb_drive_control_status_words.sv
`timescale 1ns/1ps
module tb_drive_control_status_words;
    localparam SW = 16;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic send = 1'b0;
    logic [15:0] word = 16'h0000;
    logic sup = 1'b1, ini = 1'b1, flt = 1'b0, alm = 1'b0, mrq = 1'b0, mot = 1'b0, drv = 1'b0;
    logic still = 1'b0;
    logic signed [SW-1:0] sp = 0, act = 1, cmps = 0;
    logic [SW-1:0] tol = 0, trq = 0, lim = 0;
    wire [15:0] cmd;
    wire valid, pe, rh, rd, qs, co, fa;
    wire signed [SW-1:0] spo, pot;
    wire [15:0] sw;
    int mismatches = 0;
    int cmp_count = 0;
    int i;
    // Free-running clock, 8 ns
    always #4 clk_i = ~clk_i;
    dcsw_master_model plc (.clk_i(clk_i), .word_i(word), .send_i(send),
        .drive_command_word_o(cmd), .cmd_valid_o(valid));
    dcsw_core dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .drive_command_word_i(cmd),
        .cmd_valid_i(valid), .supply_ok_i(sup), .init_done_i(ini), .fault_i(flt),
        .alarm_i(alm), .master_req_i(mrq), .mot_overtemp_i(mot), .drv_overload_i(drv),
        .standstill_i(still), .setpoint_i(sp), .actual_speed_i(act), .speed_tol_i(tol),
        .cmp_speed_i(cmps), .torque_i(trq), .torque_limit_i(lim), .pulse_enable_o(pe),
        .ramp_hold_o(rh), .ramp_down_o(rd), .quick_stop_o(qs), .coast_o(co),
        .fault_ack_o(fa), .setpoint_o(spo), .pot_value_o(pot), .drive_state_word_o(sw));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // New word, then time for the synchronised state to settle
    task automatic put(input logic [15:0] w);
        word = w;
        tick(8);
    endtask
    // Expected direction, torque, speed-reached and tolerance bits
    function automatic logic [3:0] spd_exp(input logic signed [SW-1:0] s, a, c,
        input logic [SW-1:0] t, q, l);
        logic signed [SW:0] d;
        d = s - a;
        if (d < 0) d = -d;
        spd_exp = {a > 0, q < l, a >= c, d <= t};
    endfunction
    task automatic end_sim;
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog, far beyond the expected run of about 330 cycles
    initial begin
        #40000;
        mismatches++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h45da));
        tick(2);
        check({sw[7:0], pe, rh, rd, qs, co, fa}, 14'h001a);
        rst_b_i = 1'b1;
        send = 1'b1;
        put(16'h0406);
        check(sw[6:0], 7'h31);
        put(16'h0407);
        check({sw[2:1], pe}, 3'h2);
        put(16'h040f);
        check({sw[2], pe}, 2'h3);
        put(16'h0407);
        check(pe, 0);
        put(16'h0000);
        check({co, pe}, 0);
        put(16'h0407);
        flt = 1'b1;
        tick(8);
        check({sw[3], sw[1]}, 2'h2);
        flt = 1'b0;
        tick(8);
        check(sw[3], 1);
        word = 16'h0486;
        for (i = 0; i < 6 && fa !== 1'b1; i++) tick(1);
        check(fa, 1);
        tick(8);
        check(sw[3], 0);
        put(16'h0407);
        put(16'h0487);
        check(sw[6], 1);
        put(16'h0406);
        check({sw[6], sw[0]}, 2'h1);
        ce_i = 1'b0;
        put(16'h0407);
        check(sw[1], 0);
        ce_i = 1'b1;
        tick(8);
        check(sw[1], 1);
        sp = 16'sd300;
        put(16'h2c6f);
        check(spo, -16'sd300);
        check(pot, 16'h0005);
        check({rh, rd, qs}, 3'h0);
        put(16'h440f);
        check(pot, 16'h0003);
        check({rh, rd}, 2'h3);
        for (i = 0; i < 8; i++) begin
            {alm, mrq, mot, drv} = 4'($urandom);
            tick(8);
            check({sw[15], sw[13], sw[9], sw[7]}, {!drv, !mot, mrq, alm});
        end
        for (i = 0; i < 16; i++) begin
            sp = 16'($urandom_range(4000)) - 16'sd2000;
            act = 16'($urandom_range(4000)) - 16'sd2000;
            if (act == 0) act = 1;
            cmps = (i == 0) ? act : 16'($urandom_range(4000)) - 16'sd2000;
            tol = 16'($urandom_range(600));
            trq = 16'($urandom_range(1000));
            lim = (i == 0) ? trq : 16'($urandom_range(1000));
            still = 1'($urandom);
            tick(6);
            check({sw[14], sw[11], sw[10], sw[8]}, spd_exp(sp, act, cmps, tol, trq, lim));
        end
        // Ramp stop, then quick stop, each finished by standstill; then coast
        still = 1'b0;
        put(16'h040e);
        check({sw[2], rd}, 2'h3);
        still = 1'b1;
        tick(4);
        check({sw[2], sw[0]}, 2'h1);
        still = 1'b0;
        put(16'h040f);
        put(16'h040b);
        check({qs, sw[5], sw[2]}, 3'h5);
        still = 1'b1;
        tick(4);
        check({sw[6], sw[2]}, 2'h2);
        put(16'h040d);
        check({co, sw[4]}, 2'h2);
        end_sim;
    end
endmodule
